// ===== rtl/port_fields.sv
// Purpose: wake, test mode, ownership and power fields of one port
// Assumes: writes and configured flag are synchronous to REF_CLK
// Notes: other status fields read as zero here
`timescale 1ns/100ps
module port_fields
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic ce,
	input wire logic configured_flag,
	input wire logic cf_rise,
	input wire logic power_switch_capability,
	port_fields_if.port pf
);
	logic wake_on_attach_enable;
	logic [3:0] test_mode_select;
	logic companion_ownership_bit;
	logic power_switch_bit;
	logic power_eff;

	// ----------------------------------------
	// Writable fields
	// ----------------------------------------
	// Wake enable and test selector are plain storage
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			wake_on_attach_enable <= port_ctl_pkg::WAKE_ON_ATTACH_RESET;
			test_mode_select <= port_ctl_pkg::TEST_MODE_RESET;
		end
		else if (ce && pf.wr)
		begin
			wake_on_attach_enable <= pf.wdata[port_ctl_pkg::WAKE_ON_ATTACH_BIT];
			test_mode_select <= pf.wdata[port_ctl_pkg::TEST_MODE_MSB:port_ctl_pkg::TEST_MODE_LSB];
		end
	end

	// Ownership: forced to companion while unconfigured, cleared on configure
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			companion_ownership_bit <= port_ctl_pkg::OWNER_RESET;
		else if (ce)
		begin
			if (!configured_flag)
				companion_ownership_bit <= 1'b1;
			else if (cf_rise)
				companion_ownership_bit <= 1'b0;
			else if (pf.wr)
				companion_ownership_bit <= pf.wdata[port_ctl_pkg::OWNER_BIT];
		end
	end

	// Power switch: overcurrent cut-off beats a same-cycle software write while the bit is set; once it is 0 a write can set it again
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			power_switch_bit <= port_ctl_pkg::POWER_RESET;
		else if (ce && power_switch_capability)
		begin
			if (pf.overcurrent && power_switch_bit)
				power_switch_bit <= 1'b0;
			else if (pf.wr)
				power_switch_bit <= pf.wdata[port_ctl_pkg::POWER_BIT];
		end
	end

	// ----------------------------------------
	// Derived outputs
	// ----------------------------------------
	// Without a switch the port is always powered
	assign power_eff = power_switch_capability ? power_switch_bit : 1'b1;
	assign pf.powered = power_eff;
	assign pf.owned_by_companion = companion_ownership_bit;
	// Connect counts as wake only when enabled and powered
	assign pf.wake_evt = wake_on_attach_enable && pf.attach_evt && power_eff;
	// One-hot test line decode; reserved codes select nothing
	always_comb
	begin
		pf.test_mode = 6'h00;
		case (test_mode_select)
			port_ctl_pkg::TM_J_STATE: pf.test_mode = 6'h01;
			port_ctl_pkg::TM_K_STATE: pf.test_mode = 6'h02;
			port_ctl_pkg::TM_SE0_NAK: pf.test_mode = 6'h04;
			port_ctl_pkg::TM_PACKET: pf.test_mode = 6'h08;
			port_ctl_pkg::TM_FORCE_ENABLE: pf.test_mode = 6'h10;
			default: pf.test_mode = 6'h00;
		endcase
	end
	// Readback view of this port's fields
	always_comb
	begin
		pf.rdata = 32'h0000_0000;
		pf.rdata[port_ctl_pkg::WAKE_ON_ATTACH_BIT] = wake_on_attach_enable;
		pf.rdata[port_ctl_pkg::TEST_MODE_MSB:port_ctl_pkg::TEST_MODE_LSB] = test_mode_select;
		pf.rdata[port_ctl_pkg::OWNER_BIT] = companion_ownership_bit;
		pf.rdata[port_ctl_pkg::POWER_BIT] = power_eff;
	end
endmodule

// ===== pkg/port_ctl_pkg.sv
// Purpose: constants for the port status/control field block
// Assumes: one 32-bit port status/control register per port
// Notes: field positions and reset values live here only
package port_ctl_pkg;
	localparam logic [7:0] PORT_STATUS_CONTROL_OFFSET = 8'h64;
	localparam logic [7:0] PORT_STRIDE = 8'h04;
	localparam int PORT_COUNT = 2;
	localparam int WAKE_ON_ATTACH_BIT = 20;
	localparam int TEST_MODE_LSB = 16;
	localparam int TEST_MODE_MSB = 19;
	localparam int OWNER_BIT = 13;
	localparam int POWER_BIT = 12;
	localparam logic WAKE_ON_ATTACH_RESET = 1'h0;
	localparam logic [3:0] TEST_MODE_RESET = 4'h0;
	localparam logic OWNER_RESET = 1'h1;
	localparam logic POWER_RESET = 1'h0;
	localparam logic [3:0] TM_OFF = 4'h0;
	localparam logic [3:0] TM_J_STATE = 4'h1;
	localparam logic [3:0] TM_K_STATE = 4'h2;
	localparam logic [3:0] TM_SE0_NAK = 4'h3;
	localparam logic [3:0] TM_PACKET = 4'h4;
	localparam logic [3:0] TM_FORCE_ENABLE = 4'h5;
	localparam int POWER_SETTLE_MS = 20;
	localparam int CLK_HZ = 50000000;
	localparam int POWER_SETTLE_CYCLES = POWER_SETTLE_MS * (CLK_HZ / 1000);
endpackage

// ===== pkg/port_fields_if.sv
// Purpose: bundle between register top and per-port field logic
// Assumes: single clock domain
// Notes: one instance per port
`timescale 1ns/100ps
interface port_fields_if;
	logic wr;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic attach_evt;
	logic overcurrent;
	logic wake_evt;
	logic owned_by_companion;
	logic powered;
	logic [5:0] test_mode;
	modport top (output wr, output wdata, output attach_evt, output overcurrent,
		input rdata, input wake_evt, input owned_by_companion, input powered, input test_mode);
	modport port (input wr, input wdata, input attach_evt, input overcurrent,
		output rdata, output wake_evt, output owned_by_companion, output powered, output test_mode);
endinterface

// ===== rtl/port_control_top.sv
// Purpose: port status/control field logic for two downstream ports
// Assumes: simple synchronous register strobes from the operational space
// Notes: wait for power settle is software's job; no timer in hardware
//
// Overview of operation
// - With wake-on-attach enabled, a connect on the port raises a wake event.
// - Test selector zero means normal operation, codes 1..5 a test mode, 6..15 no test line.
// - Codes 1..5 select J, K, SE0_NAK, test packet and force-enable.
// - A rising configured flag clears the ownership bit.
// - While the configured flag is 0 the ownership bit is held at 1.
// - Ownership bit 1 routes the port to the companion controller.
// - Without switch capability the port is powered and reads power 1, except in reset, where POWER_ON and the readback reset to 0.
// - With switch capability the power bit drives the power switch.
// - An unpowered port is nonfunctional and reports no events.
// - Overcurrent on a powered switched port clears its power bit.
// - Configured flag 1 routes ports here by default, 0 to the companion.
`timescale 1ns/100ps
module port_control_top
(
	input wire logic REF_CLK,
	input wire logic ARST_N,
	input wire logic CE,
	input wire logic CONFIGURED_FLAG,
	input wire logic POWER_SWITCH_CAPABILITY,
	input wire logic REG_WR,
	input wire logic [7:0] REG_ADDR,
	input wire logic [31:0] REG_WDATA,
	output logic [31:0] REG_RDATA,
	input wire logic [1:0] ATTACH_EVT,
	input wire logic [1:0] OVERCURRENT,
	output logic [1:0] WAKE_EVT,
	output logic [1:0] COMPANION_OWNS,
	output logic [1:0] POWER_ON,
	output logic [11:0] TEST_MODE
);
	logic cf_q;
	logic cf_rise;
	logic [31:0] next_rdata;
	port_fields_if pf0 ();
	port_fields_if pf1 ();

	// ----------------------------------------
	// Configured flag edge
	// ----------------------------------------
	// Remember the flag so its 0->1 step can reset ownership
	always_ff @(posedge REF_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			cf_q <= 1'b0;
		else if (CE)
			cf_q <= CONFIGURED_FLAG;
	end
	assign cf_rise = CONFIGURED_FLAG && !cf_q;

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	assign pf0.wr = REG_WR && (REG_ADDR == port_ctl_pkg::PORT_STATUS_CONTROL_OFFSET);
	assign pf1.wr = REG_WR && (REG_ADDR == port_ctl_pkg::PORT_STATUS_CONTROL_OFFSET + port_ctl_pkg::PORT_STRIDE);
	assign pf0.wdata = REG_WDATA;
	assign pf1.wdata = REG_WDATA;
	assign pf0.attach_evt = ATTACH_EVT[0];
	assign pf1.attach_evt = ATTACH_EVT[1];
	assign pf0.overcurrent = OVERCURRENT[0];
	assign pf1.overcurrent = OVERCURRENT[1];

	// Read mux, unmapped addresses read zero
	always_comb
	begin
		if (REG_ADDR == port_ctl_pkg::PORT_STATUS_CONTROL_OFFSET)
			next_rdata = pf0.rdata;
		else if (REG_ADDR == port_ctl_pkg::PORT_STATUS_CONTROL_OFFSET + port_ctl_pkg::PORT_STRIDE)
			next_rdata = pf1.rdata;
		else
			next_rdata = 32'h0000_0000;
	end

	// Registered read data, one cycle after address
	always_ff @(posedge REF_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
			REG_RDATA <= 32'h0000_0000;
		else if (CE)
			REG_RDATA <= next_rdata;
	end

	// ----------------------------------------
	// Per-port field logic
	// ----------------------------------------
	port_fields u_port0 (.clk(REF_CLK), .arst_n(ARST_N), .ce(CE), .configured_flag(CONFIGURED_FLAG),
		.cf_rise(cf_rise), .power_switch_capability(POWER_SWITCH_CAPABILITY), .pf(pf0.port));
	port_fields u_port1 (.clk(REF_CLK), .arst_n(ARST_N), .ce(CE), .configured_flag(CONFIGURED_FLAG),
		.cf_rise(cf_rise), .power_switch_capability(POWER_SWITCH_CAPABILITY), .pf(pf1.port));

	// Outputs registered so the pins see clean levels
	always_ff @(posedge REF_CLK or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			WAKE_EVT <= 2'h0;
			COMPANION_OWNS <= {2{port_ctl_pkg::OWNER_RESET}};
			POWER_ON <= {2{port_ctl_pkg::POWER_RESET}};
			TEST_MODE <= 12'h000;
		end
		else if (CE)
		begin
			WAKE_EVT <= {pf1.wake_evt, pf0.wake_evt};
			COMPANION_OWNS <= {pf1.owned_by_companion, pf0.owned_by_companion};
			POWER_ON <= {pf1.powered, pf0.powered};
			TEST_MODE <= {pf1.test_mode, pf0.test_mode};
		end
	end
endmodule

// ===== tb/port_ctl_props.sv
// Purpose: port field checker
// Assumes: bound to port_control_top
// Notes: sees the top ports only
`timescale 1ns/100ps
module port_ctl_props
(
	input wire logic REF_CLK,
	input wire logic ARST_N,
	input wire logic CE,
	input wire logic CONFIGURED_FLAG,
	input wire logic POWER_SWITCH_CAPABILITY,
	input wire logic REG_WR,
	input wire logic [7:0] REG_ADDR,
	input wire logic [31:0] REG_WDATA,
	input wire logic [31:0] REG_RDATA,
	input wire logic [1:0] ATTACH_EVT,
	input wire logic [1:0] OVERCURRENT,
	input wire logic [1:0] WAKE_EVT,
	input wire logic [1:0] COMPANION_OWNS,
	input wire logic [1:0] POWER_ON,
	input wire logic [11:0] TEST_MODE
);
	// Frozen cycles (CE low) are kept out of every antecedent
	default clocking @(posedge REF_CLK);
	endclocking
	default disable iff (!ARST_N);
	wake_cause_a: assert property (WAKE_EVT[0] && $past(CE) |-> $past(ATTACH_EVT[0]))
		else $error("wake without connect");
	own_held_a: assert property (!CONFIGURED_FLAG && CE ##1 CE |=> COMPANION_OWNS == 2'h3)
		else $error("owner not held");
	own_clear_a: assert property ($rose(CONFIGURED_FLAG) && CE ##1 CE |=> COMPANION_OWNS == 2'h0)
		else $error("owner not cleared");
	own_read_a: assert property (CE && REG_ADDR == 8'h64 |=> REG_RDATA[13] == COMPANION_OWNS[0])
		else $error("owner readback");
	pow_fixed_a: assert property ((!POWER_SWITCH_CAPABILITY && CE) [*2] |=> POWER_ON == 2'h3)
		else $error("unswitched port off");
	pow_read_a: assert property ((!POWER_SWITCH_CAPABILITY && CE) [*2] ##0 REG_ADDR == 8'h64 |=> REG_RDATA[12])
		else $error("power reads 0");
	pow_trip_a: assert property ((POWER_SWITCH_CAPABILITY && OVERCURRENT[0] && CE) [*2] |=> !POWER_ON[0])
		else $error("overcurrent kept power");
	pow_set_a: assert property (REG_WR && CE && REG_ADDR == 8'h64 && REG_WDATA[12] && !OVERCURRENT[0]
		##1 CE |=> POWER_ON[0])
		else $error("power write lost");
	tm_idle_a: assert property (REG_WR && CE && REG_ADDR == 8'h64 && REG_WDATA[19:16] == 4'h0
		##1 CE |=> TEST_MODE[5:0] == 6'h00)
		else $error("test line without code");
endmodule
bind port_control_top port_ctl_props chk_u (.*);

// ===== tb/usb_dev_model.sv
// Purpose: attached devices on the two ports
// Assumes: plug and short change just after an edge
// Notes: a short only draws current on a powered port
`timescale 1ns/100ps
module usb_dev_model
(
	input wire logic clk,
	input wire logic [1:0] plug,
	input wire logic [1:0] short_req,
	input wire logic [1:0] powered,
	output logic [1:0] attach,
	output logic [1:0] overcurrent
);
	logic [1:0] plug_q = 2'h0;
	// One-cycle connect pulse on each plug-in
	always_ff @(posedge clk)
		plug_q <= plug;
	assign attach = plug & ~plug_q;
	assign overcurrent = short_req & powered;
endmodule

// ===== tb/testbench.sv
// Purpose: self-checking bench for port_control_top
// Assumes: inputs change 1 ns after each rising edge
// Notes: reset and ownership checks, then table rows, then hand-written cases
`timescale 1ns/100ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin failures++; $display("[FAIL] %0t bad value", $time); end end
module testbench;
	typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] q; logic [5:0] tm;} row_s;
	logic REF_CLK = 1'h0;
	logic ARST_N = 1'h0;
	logic CE = 1'h1;
	logic CONFIGURED_FLAG = 1'h0;
	logic POWER_SWITCH_CAPABILITY = 1'h1;
	logic REG_WR = 1'h0;
	logic [7:0] REG_ADDR = 8'h64;
	logic [31:0] REG_WDATA = 32'h0;
	logic [1:0] plug = 2'h0;
	logic [1:0] short_req = 2'h0;
	logic [31:0] REG_RDATA;
	logic [1:0] ATTACH_EVT, OVERCURRENT, WAKE_EVT, COMPANION_OWNS, POWER_ON;
	logic [11:0] TEST_MODE;
	int failures = 0;
	int cmp_count = 0;
	// Every test code, port 1 and a final power-up with wake enabled
	row_s rows [8] = '{'{8'h64, 32'h00100000, 32'h00100000, 6'h00}, '{8'h64, 32'h00011000, 32'h00011000, 6'h01},
		'{8'h64, 32'h00021000, 32'h00021000, 6'h02}, '{8'h64, 32'h00031000, 32'h00031000, 6'h04},
		'{8'h64, 32'h00041000, 32'h00041000, 6'h08}, '{8'h64, 32'h00051000, 32'h00051000, 6'h10},
		'{8'h68, 32'h00103000, 32'h00103000, 6'h00}, '{8'h64, 32'h00101000, 32'h00101000, 6'h00}};
	port_control_top dut_u (.*);
	usb_dev_model dev_u (.clk(REF_CLK), .plug(plug), .short_req(short_req), .powered(POWER_ON),
		.attach(ATTACH_EVT), .overcurrent(OVERCURRENT));
	always #10 REF_CLK = ~REF_CLK;
	// Write then hold the address two edges so fields and readback settle
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		REG_ADDR = a;
		REG_WDATA = d;
		REG_WR = 1'h1;
		@(posedge REF_CLK) #1;
		REG_WR = 1'h0;
		// Model power is steady at once, so two edges of settle are enough
		repeat (2) @(posedge REF_CLK) #1;
	endtask
	task automatic complete_run();
		$display("failures=%0d cmp_count=%0d", failures, cmp_count);
		if (failures == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// ----------------
	// Main sequence
	// ----------------
	initial
	begin
		repeat (8) @(posedge REF_CLK) #1;
		ARST_N = 1'h1;
		wr(8'h64, 32'h0);
		`CHK(REG_RDATA, 32'h00002000)
		`CHK(COMPANION_OWNS, 2'h3)
		CONFIGURED_FLAG = 1'h1;
		repeat (3) @(posedge REF_CLK) #1;
		`CHK(COMPANION_OWNS, 2'h0)
		foreach (rows[i])
		begin
			wr(rows[i].a, rows[i].d);
			`CHK(REG_RDATA, rows[i].q)
			`CHK(TEST_MODE[rows[i].a[3] * 6 +: 6], rows[i].tm)
			`CHK(COMPANION_OWNS[rows[i].a[3]], rows[i].q[13])
			`CHK(POWER_ON[rows[i].a[3]], rows[i].q[12])
		end
		plug = 2'h1;
		@(posedge REF_CLK) #1;
		`CHK(WAKE_EVT, 2'h1)
		// Short trips power even against a same-cycle power write
		short_req = 2'h1;
		plug = 2'h0;
		wr(8'h64, 32'h00101000);
		`CHK(POWER_ON[0], 1'h0)
		`CHK(REG_RDATA[12], 1'h0)
		plug = 2'h1;
		@(posedge REF_CLK) #1;
		`CHK(WAKE_EVT[0], 1'h0)
		short_req = 2'h0;
		POWER_SWITCH_CAPABILITY = 1'h0;
		wr(8'h64, 32'h0);
		`CHK(POWER_ON, 2'h3)
		`CHK(REG_RDATA[12], 1'h1)
		CONFIGURED_FLAG = 1'h0;
		wr(8'h68, 32'h0);
		`CHK(COMPANION_OWNS, 2'h3)
		// Frozen clock enable: a write to port 0 must not land
		CE = 1'h0;
		wr(8'h64, 32'h00100000);
		CE = 1'h1;
		repeat (2) @(posedge REF_CLK) #1;
		`CHK(REG_RDATA, 32'h00003000)
		// Second reset in mid-run: fields and outputs return to defaults
		ARST_N = 1'h0;
		@(posedge REF_CLK) #1;
		`CHK(COMPANION_OWNS, 2'h3)
		`CHK(POWER_ON, 2'h0)
		`CHK(REG_RDATA, 32'h00000000)
		ARST_N = 1'h1;
		POWER_SWITCH_CAPABILITY = 1'h1;
		repeat (2) @(posedge REF_CLK) #1;
		`CHK(REG_RDATA, 32'h00002000)
		`CHK(POWER_ON, 2'h0)
		complete_run();
	end
	// Run needs about 60 cycles; 5000 cycles means a hang
	initial
	begin
		#100000;
		failures++;
		complete_run();
	end
endmodule
